// ### cic_flag_bank.sv
// Sticky interrupt flag register with software write access.
`timescale 1ns/10ps
module cic_flag_bank #(
  parameter int W = 8
) (
  // Clock and synchronised reset.
  input wire logic clk,
  input wire logic rstN,
  // Software write of the whole register.
  input wire logic wrEn,
  input wire logic [W-1:0] wrData,
  // One-cycle set events, one per flag.
  input wire logic [W-1:0] setEv,
  // Current flags.
  output logic [W-1:0] flags
);

  // The flag word is the whole state.
  typedef struct packed {
    logic [W-1:0] flags;
  } cic_flag_s;

  cic_flag_s st;
  cic_flag_s next_st;

  // A write replaces the word, but an event in the same cycle still
  // sets its flag, so no event is lost to a clearing write.
  always_comb begin
    next_st = st;
    if (wrEn) begin
      next_st.flags = wrData;
    end
    next_st.flags = next_st.flags | setEv;
  end

  // All flags clear at reset.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      st.flags <= W'(cic_pkg::FLAGS_RST);
    end else begin
      st <= next_st;
    end
  end

  assign flags = st.flags;

endmodule : cic_flag_bank

// ### cic_irq_io_ctrl.sv
// Controller interrupt registers, pin control and register address map.
`timescale 1ns/10ps
module cic_irq_io_ctrl (
  // Clock and asynchronous active-low reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Processor data-memory port.
  input wire logic [7:0] cpuAddr,
  input wire logic cpuAccessBank,
  input wire logic [3:0] cpuBankSel,
  input wire logic cpuWr,
  input wire logic cpuRd,
  input wire logic [7:0] cpuWdata,
  output logic [7:0] cpuRdata,
  // Other controller registers, held elsewhere in the module.
  output logic canRegWr,
  output logic canRegRd,
  output logic [6:0] canRegOfs,
  input wire logic [7:0] canRegRdata,
  // Status and mode from the mode machine.
  input wire logic [7:0] ctrlStatus,
  input wire logic [2:0] opMode,
  output logic errCntClear,
  // Event pulses from the protocol engine and buffers.
  input wire logic invalidMsgEv,
  input wire logic busWakeEv,
  input wire logic moduleErrEv,
  input wire logic [2:0] txBufDoneEv,
  input wire logic [1:0] rxBufFullEv,
  // Interrupt requests toward the processor.
  output logic irqHigh,
  output logic irqLow,
  // Transmit bit from the protocol engine, zero is dominant.
  input wire logic txBit,
  // Transmit pin toward the transceiver.
  output logic bus_transmit_pin_o,
  output logic bus_transmit_pin_oe,
  // Capture path.
  input wire logic rxMsgSignal,
  input wire logic capture_port_pin,
  output logic captureIn
);

  // Target of a decoded processor address.
  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_FLAGS = 3'b001,
    SEL_ENABLES = 3'b010,
    SEL_PRIOS = 3'b011,
    SEL_PINCTRL = 3'b100,
    SEL_STATUS = 3'b101,
    SEL_UNUSED = 3'b110,
    SEL_OTHER = 3'b111
  } cic_sel_e;

  // All registered state of this module.
  typedef struct packed {
    logic [1:0] pinCtrl;
    logic [7:0] enables;
    logic [7:0] prios;
    logic [7:0] rdata;
    logic [2:0] prevMode;
    logic errClr;
    logic txOut;
    logic txOe;
    logic capOut;
    logic irqHi;
    logic irqLo;
  } cic_main_s;

  // Full 12-bit data address from the bank-select scheme.
  function automatic logic [11:0] effAddr(
    input logic [7:0] ofs,
    input logic acc,
    input logic [3:0] bank
  );
    logic [11:0] a;
    a = {bank, ofs};
    if (acc && ofs >= cic_pkg::ACCESS_SPLIT) begin
      a = {cic_pkg::SFR_BANK, ofs};
    end else if (acc) begin
      // Low access area is ordinary RAM in bank 0.
      a = {4'h0, ofs};
    end
    return a;
  endfunction : effAddr

  // Classify one full address.
  function automatic cic_sel_e decode(input logic [11:0] a);
    cic_sel_e s;
    s = SEL_NONE;
    if (a == cic_pkg::IRQ_FLAGS_ADDR) begin
      s = SEL_FLAGS;
    end else if (a == cic_pkg::IRQ_ENABLES_ADDR) begin
      s = SEL_ENABLES;
    end else if (a == cic_pkg::IRQ_PRIOS_ADDR) begin
      s = SEL_PRIOS;
    end else if (a < cic_pkg::SPACE_LO || a > cic_pkg::SPACE_HI) begin
      // Outside the controller space: not ours.
      s = SEL_NONE;
    end else if (a >= cic_pkg::UNUSED_TOP_LO ||
                 a == cic_pkg::UNUSED_HOLE_A ||
                 a == cic_pkg::UNUSED_HOLE_B ||
                 a == cic_pkg::UNUSED_HOLE_C ||
                 a == cic_pkg::UNUSED_HOLE_D) begin
      s = SEL_UNUSED;
    end else if (a == cic_pkg::PIN_IO_CTRL_ADDR) begin
      s = SEL_PINCTRL;
    end else if (a == cic_pkg::STATUS_ADDR ||
                 a == cic_pkg::STATUS_MIR_A ||
                 a == cic_pkg::STATUS_MIR_B ||
                 a == cic_pkg::STATUS_MIR_C ||
                 a == cic_pkg::STATUS_MIR_D) begin
      s = SEL_STATUS;
    end else begin
      s = SEL_OTHER;
    end
    return s;
  endfunction : decode

  // Synchronised reset; everything else uses this copy.
  logic rstSyncN;
  // Capture port pin after two flip-flops.
  logic capPinSync;
  // Decoded address of the current access.
  logic [11:0] curAddr;
  cic_sel_e curSel;
  // Current flags and the gated set events.
  logic [7:0] flags;
  logic [7:0] rawEv;
  logic [7:0] gatedEv;
  logic flagWr;
  // Module state and its next value.
  cic_main_s st;
  cic_main_s next_st;

  // Reset release: the deassertion is retimed to the clock.
  cic_sync2 #(
    .W(1)
  ) u_rst_sync (
    .clk(sys_clk),
    .rstN(rst_n),
    .d(1'b1),
    .q(rstSyncN)
  );

  // The port pin comes from outside the clock domain.
  cic_sync2 #(
    .W(1)
  ) u_pin_sync (
    .clk(sys_clk),
    .rstN(rstSyncN),
    .d(capture_port_pin),
    .q(capPinSync)
  );

  // Address decode is shared by reads and writes.
  always_comb begin
    curAddr = effAddr(cpuAddr, cpuAccessBank, cpuBankSel);
    curSel = decode(curAddr);
  end

  // Collect events into flag positions.
  always_comb begin
    rawEv = '0;
    rawEv[cic_pkg::INVALID_MSG_BIT] = invalidMsgEv;
    rawEv[cic_pkg::BUS_WAKE_BIT] = busWakeEv;
    rawEv[cic_pkg::MODULE_ERR_BIT] = moduleErrEv;
    rawEv[cic_pkg::TX_BUF2_BIT:cic_pkg::TX_BUF0_BIT] = txBufDoneEv;
    rawEv[cic_pkg::RX_BUF1_BIT:cic_pkg::RX_BUF0_BIT] = rxBufFullEv;
    gatedEv = rawEv;
    if (opMode == cic_pkg::MODE_DISABLE) begin
      gatedEv = '0;
      gatedEv[cic_pkg::BUS_WAKE_BIT] = busWakeEv;
    end
  end

  // Software writes to the flag register.
  assign flagWr = cpuWr && (curSel == SEL_FLAGS);

  // Sticky flags; an event beats a clearing write in the same cycle.
  // flag register
  cic_flag_bank #(
    .W(8)
  ) u_flags (
    .clk(sys_clk),
    .rstN(rstSyncN),
    .wrEn(flagWr),
    .wrData(cpuWdata),
    .setEv(gatedEv),
    .flags(flags)
  );

  // Strobes toward registers held in other parts of the module.
  // Unused holes are never forwarded, so nothing can answer there.
  always_comb begin
    canRegWr = cpuWr && (curSel == SEL_OTHER);
    canRegRd = cpuRd && (curSel == SEL_OTHER);
    canRegOfs = curAddr[6:0];
  end

  // Next-state logic for the whole module.
  always_comb begin
    next_st = st;

    // Register writes.
    if (cpuWr) begin
      case (curSel)
        SEL_ENABLES: begin
          next_st.enables = cpuWdata;
        end
        SEL_PRIOS: begin
          next_st.prios = cpuWdata;
        end
        SEL_PINCTRL: begin
          next_st.pinCtrl = {cpuWdata[cic_pkg::DRIVE_HIGH_BIT],
                             cpuWdata[cic_pkg::CAPTURE_ROUTE_BIT]};
        end
        default: begin
          // Status is read-only; other targets are handled elsewhere.
        end
      endcase
    end

    // Read data is captured on the read edge and held until the next read.
    if (cpuRd) begin
      case (curSel)
        SEL_FLAGS: begin
          next_st.rdata = flags;
        end
        SEL_ENABLES: begin
          next_st.rdata = st.enables;
        end
        SEL_PRIOS: begin
          next_st.rdata = st.prios;
        end
        SEL_PINCTRL: begin
          next_st.rdata = '0;
          next_st.rdata[cic_pkg::DRIVE_HIGH_BIT] = st.pinCtrl[1];
          next_st.rdata[cic_pkg::CAPTURE_ROUTE_BIT] = st.pinCtrl[0];
        end
        SEL_STATUS: begin
          next_st.rdata = ctrlStatus;
        end
        SEL_OTHER: begin
          next_st.rdata = canRegRdata;
        end
        default: begin
          // Unused holes and foreign addresses read as zero.
          next_st.rdata = '0;
        end
      endcase
    end

    next_st.prevMode = opMode;
    next_st.errClr = (opMode == cic_pkg::MODE_CONFIG) &&
                     (st.prevMode != cic_pkg::MODE_CONFIG);

    // recessive drive select
    // Dominant always drives low; recessive drives high or floats.
    if (!txBit) begin
      next_st.txOut = 1'b0;
      next_st.txOe = 1'b1;
    end else begin
      next_st.txOut = 1'b1;
      next_st.txOe = st.pinCtrl[1];
    end

    next_st.capOut = st.pinCtrl[0] ? rxMsgSignal : capPinSync;

    // priority split requests
    // The requests follow flags one cycle later, which keeps them glitch free.
    next_st.irqHi = |(flags & st.enables & st.prios);
    next_st.irqLo = |(flags & st.enables & ~st.prios);
  end

  // One register stage for all state; reset gives constants only.
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      st.pinCtrl <= cic_pkg::PIN_CTRL_RST;
      st.enables <= cic_pkg::ENABLES_RST;
      st.prios <= cic_pkg::PRIOS_RST;
      st.rdata <= 8'h00;
      st.prevMode <= 3'h0;
      st.errClr <= 1'b0;
      // Recessive and floating until the first edge.
      st.txOut <= 1'b1;
      st.txOe <= 1'b0;
      st.capOut <= 1'b0;
      st.irqHi <= 1'b0;
      st.irqLo <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register.
  assign cpuRdata = st.rdata;
  assign errCntClear = st.errClr;
  assign irqHigh = st.irqHi;
  assign irqLow = st.irqLo;
  assign bus_transmit_pin_o = st.txOut;
  assign bus_transmit_pin_oe = st.txOe;
  assign captureIn = st.capOut;

endmodule : cic_irq_io_ctrl

// ### cic_irq_io_ctrl_properties.sv
// Port-level checker for the interrupt, pin and address-map block.
`timescale 1ns/10ps
module cic_irq_io_ctrl_properties (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Processor port.
  input wire logic [7:0] cpuAddr,
  input wire logic cpuAccessBank,
  input wire logic cpuWr,
  input wire logic cpuRd,
  input wire logic [7:0] cpuRdata,
  input wire logic canRegWr,
  input wire logic canRegRd,
  input wire logic [6:0] canRegOfs,
  // Status, mode, pin and capture.
  input wire logic [7:0] ctrlStatus,
  input wire logic [2:0] opMode,
  input wire logic errCntClear,
  input wire logic txBit,
  input wire logic bus_transmit_pin_o,
  input wire logic bus_transmit_pin_oe,
  input wire logic rxMsgSignal,
  input wire logic capture_port_pin,
  input wire logic captureIn
);
  // Cycles since release; checks wait out the internal release and the pin pipes.
  logic [2:0] upCnt;
  logic rdy;
  logic accHi;
  // Saturating count after reset.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      upCnt <= 3'h0;
    end else if (upCnt != 3'h7) begin
      upCnt <= upCnt + 3'h1;
    end
  end
  assign rdy = (upCnt == 3'h7);
  // Access-bank address in the upper controller area.
  assign accHi = cpuAccessBank && (cpuAddr >= 8'h60);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rdy);
  property p_dom_drive;
    !$past(txBit) |-> bus_transmit_pin_oe && !bus_transmit_pin_o;
  endproperty
  a_dom_drive: assert property (p_dom_drive) else $error("dominant not driven");
  property p_rec_level;
    $past(txBit) && bus_transmit_pin_oe |-> bus_transmit_pin_o;
  endproperty
  a_rec_level: assert property (p_rec_level) else $error("recessive driven low");
  property p_cap_src;
    $past(rxMsgSignal) == $past(capture_port_pin, 3) |-> captureIn == $past(rxMsgSignal);
  endproperty
  a_cap_src: assert property (p_cap_src) else $error("capture source wrong");
  property p_status;
    cpuRd && accHi && cpuAddr == 8'h6E |=> cpuRdata == $past(ctrlStatus);
  endproperty
  a_status: assert property (p_status) else $error("status read wrong");
  property p_unused_rd;
    cpuRd && accHi && cpuAddr >= 8'h77 && cpuAddr <= 8'h7F |=> cpuRdata == 8'h00;
  endproperty
  a_unused_rd: assert property (p_unused_rd) else $error("unused read not zero");
  property p_unused_strb;
    (cpuRd || cpuWr) && accHi && cpuAddr >= 8'h77 |-> !canRegRd && !canRegWr;
  endproperty
  a_unused_strb: assert property (p_unused_strb) else $error("unused strobed");
  property p_hi_strb;
    cpuRd && accHi && cpuAddr < 8'h6E |-> canRegRd && canRegOfs == cpuAddr[6:0];
  endproperty
  a_hi_strb: assert property (p_hi_strb) else $error("access bank miss");
  property p_lo_area;
    (cpuRd || cpuWr) && cpuAccessBank && cpuAddr < 8'h60 |-> !canRegRd && !canRegWr;
  endproperty
  a_lo_area: assert property (p_lo_area) else $error("low area strobed");
  property p_err_clr;
    opMode == cic_pkg::MODE_CONFIG && $past(opMode) != cic_pkg::MODE_CONFIG
      |=> errCntClear ##1 !errCntClear;
  endproperty
  a_err_clr: assert property (p_err_clr) else $error("counter clear pulse wrong");
endmodule : cic_irq_io_ctrl_properties

bind cic_irq_io_ctrl cic_irq_io_ctrl_properties u_props (.sys_clk, .rst_n, .cpuAddr,
  .cpuAccessBank, .cpuWr, .cpuRd, .cpuRdata, .canRegWr, .canRegRd, .canRegOfs,
  .ctrlStatus, .opMode, .errCntClear, .txBit, .bus_transmit_pin_o, .bus_transmit_pin_oe,
  .rxMsgSignal, .capture_port_pin, .captureIn);

// ### cic_pkg.sv
// Shared constants for the controller interrupt, pin and address-map block.
package cic_pkg;

  // Width of every register in this block.
  localparam int DW = 8;

  // Full data addresses of the controller register space.
  localparam logic [11:0] SPACE_LO = 12'hF00;
  localparam logic [11:0] SPACE_HI = 12'hF7F;
  localparam logic [11:0] STATUS_ADDR = 12'hF6E;
  localparam logic [11:0] STATUS_MIR_A = 12'hF5E;
  localparam logic [11:0] STATUS_MIR_B = 12'hF4E;
  localparam logic [11:0] STATUS_MIR_C = 12'hF3E;
  localparam logic [11:0] STATUS_MIR_D = 12'hF2E;
  localparam logic [11:0] PIN_IO_CTRL_ADDR = 12'hF73;

  // Unused holes inside the space: F77h to F7Fh and four single bytes.
  localparam logic [11:0] UNUSED_TOP_LO = 12'hF77;
  localparam logic [11:0] UNUSED_HOLE_A = 12'hF5F;
  localparam logic [11:0] UNUSED_HOLE_B = 12'hF4F;
  localparam logic [11:0] UNUSED_HOLE_C = 12'hF3F;
  localparam logic [11:0] UNUSED_HOLE_D = 12'hF2F;

  // Interrupt register addresses; placement outside the controller space.
  localparam logic [11:0] IRQ_FLAGS_ADDR = 12'hF80;
  localparam logic [11:0] IRQ_ENABLES_ADDR = 12'hF81;
  localparam logic [11:0] IRQ_PRIOS_ADDR = 12'hF82;

  // Access bank: low offsets below this reach ordinary RAM, the rest bank 15.
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] SFR_BANK = 4'hF;

  // Pin control field positions.
  localparam int DRIVE_HIGH_BIT = 5;
  localparam int CAPTURE_ROUTE_BIT = 4;

  // Flag bit positions.
  localparam int INVALID_MSG_BIT = 7;
  localparam int BUS_WAKE_BIT = 6;
  localparam int MODULE_ERR_BIT = 5;
  localparam int TX_BUF2_BIT = 4;
  localparam int TX_BUF0_BIT = 2;
  localparam int RX_BUF1_BIT = 1;
  localparam int RX_BUF0_BIT = 0;

  // Reset values.
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] ENABLES_RST = 8'h00;
  localparam logic [7:0] PRIOS_RST = 8'hFF;
  localparam logic [1:0] PIN_CTRL_RST = 2'h0;

  // Operating mode codes reported by the mode machine.
  localparam logic [2:0] MODE_DISABLE = 3'h1;
  localparam logic [2:0] MODE_CONFIG = 3'h4;

endpackage : cic_pkg

// ### cic_sync2.sv
// Two-stage synchroniser, also used as the reset release stage.
`timescale 1ns/10ps
module cic_sync2 #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstN,
  // Asynchronous level in, synchronised level out.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // Both stages as one state word.
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } cic_sync_s;

  cic_sync_s st;
  cic_sync_s next_st;

  // The first stage feeds only the second stage.
  always_comb begin
    next_st.meta = d;
    next_st.stable = st.meta;
  end

  // Reset loads constants only.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.stable;

endmodule : cic_sync2

// ### cic_xcvr_model.sv
// Transceiver stand-in that resolves the bus wire from the transmit pin.
`timescale 1ns/10ps
module cic_xcvr_model (
  // Transmit pin from the block.
  input wire logic pinOut,
  input wire logic pinOe,
  // Level seen on the bus.
  output logic busLevel
);
  // Termination pulls an undriven line to recessive.
  // released pin reads recessive
  assign busLevel = pinOe ? pinOut : 1'b1;
endmodule : cic_xcvr_model

// ### test_can_irq_and_io_control.sv
// Self-checking bench for the interrupt, pin and address-map block.
`timescale 1ns/10ps
module test_can_irq_and_io_control;
  // Block inputs.
  logic sys_clk = 1'b0, rst_n = 1'b0, cpuAccessBank = 1'b0, cpuWr = 1'b0, cpuRd = 1'b0;
  logic [7:0] cpuAddr = 8'h00, cpuWdata = 8'h00, canRegRdata = 8'h00, ctrlStatus = 8'h00;
  logic [3:0] cpuBankSel = 4'h0;
  logic [2:0] opMode = 3'h0, txBufDoneEv = 3'h0;
  logic [1:0] rxBufFullEv = 2'h0;
  logic invalidMsgEv = 1'b0, busWakeEv = 1'b0, moduleErrEv = 1'b0;
  logic txBit = 1'b1, rxMsgSignal = 1'b1, capture_port_pin = 1'b0;
  // Block outputs and bus level.
  logic [7:0] cpuRdata;
  logic [6:0] canRegOfs;
  logic canRegWr, canRegRd, errCntClear, irqHigh, irqLow, pinO, pinOe, captureIn, busLevel;
  // Reference model and counters.
  int mFlags = 0, mEn = 0, mPrio = 0, errorCnt = 0, numChecks = 0, cycles = 0;
  logic [11:0] statQ[$] = '{12'hF6E, 12'hF5E, 12'hF4E, 12'hF3E, 12'hF2E};
  logic [11:0] unQ[$] = '{12'hF77, 12'hF7F, 12'hF5F, 12'hF4F, 12'hF3F, 12'hF2F, 12'hE80};
  logic [7:0] pinV[5] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'hFF};

  cic_irq_io_ctrl dut (.sys_clk, .rst_n, .cpuAddr, .cpuAccessBank, .cpuBankSel, .cpuWr,
    .cpuRd, .cpuWdata, .cpuRdata, .canRegWr, .canRegRd, .canRegOfs, .canRegRdata,
    .ctrlStatus, .opMode, .errCntClear, .invalidMsgEv, .busWakeEv, .moduleErrEv,
    .txBufDoneEv, .rxBufFullEv, .irqHigh, .irqLow, .txBit, .bus_transmit_pin_o(pinO),
    .bus_transmit_pin_oe(pinOe), .rxMsgSignal, .capture_port_pin, .captureIn);
  cic_xcvr_model xcvr (.pinOut(pinO), .pinOe(pinOe), .busLevel(busLevel));

  always #2.5 sys_clk = ~sys_clk;

  // A hang counts as a mismatch.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errorCnt++;
      summarize();
    end
  end

  task automatic summarize();
    if (errorCnt == 0 && numChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  task automatic check(input string w, input logic [7:0] seen, input logic [7:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("ERROR %s expected %h seen %h", w, exp, seen);
    end
  endtask : check

  // One register cycle; ab selects access-bank addressing.
  task automatic bus(input logic ab, input logic [11:0] a, input logic wr, input logic [7:0] d);
    @(posedge sys_clk);
    cpuAccessBank <= ab;
    cpuBankSel <= a[11:8];
    cpuAddr <= a[7:0];
    cpuWr <= wr;
    cpuRd <= !wr;
    cpuWdata <= d;
    canRegRdata <= 8'($urandom);
    @(posedge sys_clk);
    cpuWr <= 1'b0;
    cpuRd <= 1'b0;
    #1;
  endtask : bus

  task automatic rd(input logic ab, input logic [11:0] a, input logic [7:0] e, input string w);
    bus(ab, a, 1'b0, 8'h00);
    check(w, cpuRdata, e);
  endtask : rd

  // Pulse events; disabled mode keeps only the wake source.
  task automatic fire(input logic [7:0] ev);
    @(posedge sys_clk);
    {invalidMsgEv, busWakeEv, moduleErrEv, txBufDoneEv, rxBufFullEv} <= ev;
    @(posedge sys_clk);
    {invalidMsgEv, busWakeEv, moduleErrEv, txBufDoneEv, rxBufFullEv} <= 8'h00;
    mFlags |= (opMode == cic_pkg::MODE_DISABLE) ? (ev & 8'h40) : ev;
  endtask : fire

  task automatic chkIrq();
    repeat (2) @(posedge sys_clk);
    #1;
    check("irqHigh", {7'h00, irqHigh}, {7'h00, |(mFlags & mEn & mPrio)});
    check("irqLow", {7'h00, irqLow}, {7'h00, |(mFlags & mEn & ~mPrio)});
  endtask : chkIrq

  initial begin
    void'($urandom(91));
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(0, cic_pkg::IRQ_FLAGS_ADDR, 8'h00, "flags");
    rd(0, cic_pkg::IRQ_ENABLES_ADDR, 8'h00, "enables");
    rd(0, cic_pkg::IRQ_PRIOS_ADDR, 8'hFF, "prios");
    // Each source alone under random enables and priorities.
    for (int i = 0; i < 8; i++) begin
      mEn = $urandom % 256;
      mPrio = $urandom % 256;
      bus(0, cic_pkg::IRQ_ENABLES_ADDR, 1'b1, mEn[7:0]);
      bus(0, cic_pkg::IRQ_PRIOS_ADDR, 1'b1, mPrio[7:0]);
      fire(8'h01 << i);
      chkIrq();
      rd(0, cic_pkg::IRQ_FLAGS_ADDR, mFlags[7:0], "flags");
      rd(0, cic_pkg::IRQ_ENABLES_ADDR, mEn[7:0], "enables");
      rd(0, cic_pkg::IRQ_PRIOS_ADDR, mPrio[7:0], "prios");
      mFlags = (i == 7) ? 8'hA5 : 0;
      bus(0, cic_pkg::IRQ_FLAGS_ADDR, 1'b1, mFlags[7:0]);
    end
    chkIrq();
    rd(0, cic_pkg::IRQ_FLAGS_ADDR, 8'hA5, "flags");
    // Disabled mode, then configuration entry.
    @(posedge sys_clk);
    opMode <= cic_pkg::MODE_DISABLE;
    fire(8'hFF);
    rd(0, cic_pkg::IRQ_FLAGS_ADDR, mFlags[7:0], "flags");
    @(posedge sys_clk);
    opMode <= cic_pkg::MODE_CONFIG;
    // The clear pulse follows the first edge that sees the new mode.
    @(posedge sys_clk);
    #1;
    check("errCntClear", {7'h00, errCntClear}, 8'h01);
    @(posedge sys_clk);
    #1;
    check("errCntClear", {7'h00, errCntClear}, 8'h00);
    rd(0, cic_pkg::IRQ_FLAGS_ADDR, mFlags[7:0], "flags");
    // Address map: status and mirrors, holes, low area, other registers.
    @(posedge sys_clk);
    ctrlStatus <= 8'($urandom);
    // Let the new status settle before it is used as the expectation.
    #1;
    foreach (statQ[k]) rd(0, statQ[k], ctrlStatus, "status");
    rd(1, cic_pkg::STATUS_ADDR, ctrlStatus, "status");
    foreach (unQ[k]) bus(0, unQ[k], 1'b1, 8'hFF);
    foreach (unQ[k]) rd(0, unQ[k], 8'h00, "unused");
    rd(1, 12'hF7A, 8'h00, "unused");
    rd(1, 12'h010, 8'h00, "lowArea");
    bus(1, 12'hF64, 1'b0, 8'h00);
    check("otherReg", cpuRdata, canRegRdata);
    bus(0, 12'hF10, 1'b0, 8'h00);
    check("otherReg", cpuRdata, canRegRdata);
    // Pin control values against dominant and recessive bits.
    foreach (pinV[k]) begin
      bus(0, cic_pkg::PIN_IO_CTRL_ADDR, 1'b1, pinV[k]);
      rd(0, cic_pkg::PIN_IO_CTRL_ADDR, pinV[k] & 8'h30, "pinCtrl");
      for (int b = 0; b < 2; b++) begin
        @(posedge sys_clk);
        txBit <= b[0];
        rxMsgSignal <= 1'($urandom);
        capture_port_pin <= 1'($urandom);
        repeat (5) @(posedge sys_clk);
        #1;
        check("busLevel", {7'h00, busLevel}, {7'h00, b[0]});
        check("pinOe", {7'h00, pinOe}, {7'h00, !b[0] || pinV[k][5]});
        check("capture", {7'h00, captureIn},
          {7'h00, pinV[k][4] ? rxMsgSignal : capture_port_pin});
      end
    end
    summarize();
  end
endmodule : test_can_irq_and_io_control
